// >>> ssdp_pkg.sv
// shared types and constants for the sync sram data port
// Operation
// - input data on the data lines is captured on the rising clock edge.
// - reads drive the word at the address registered at the previous clock rise.
// - output enable low lets lines drive; high puts data and parity lines high-z.
// - data and parity drivers are released during every write data phase.
// - first cycle after leaving deselect keeps outputs high-z despite output enable.
// - while deselected, data and parity outputs stay high-z.
// - parity lines act like data lines; each written only with its byte select.
// - burst order strap low gives linear burst address sequence.
// - burst order strap high or open gives interleaved burst address sequence.
`default_nettype none
package ssdp_pkg;
  localparam int DATA_BYTES = 4;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 20;
  localparam int BURST_BITS = 2;
  // reset values of control state, and the burst step
  localparam logic RST_SELECTED = 1'b0;
  localparam logic RST_DRIVE = 1'b0;
  localparam logic RST_WRITE = 1'b0;
  localparam logic RST_INTERLEAVE = 1'b1;
  localparam logic [BURST_BITS-1:0] RST_BURST = 2'h0;
  localparam logic [BURST_BITS-1:0] BURST_STEP = 2'h1;

  // one bus cycle as the controller presents it at a rising edge
  typedef struct packed {
    logic select;
    logic writeEn;
    logic advance;
    logic [DATA_BYTES-1:0] byteWriteSelect;
    logic [ADDR_BITS-1:0] addr;
  } ssdp_cmd_t;

  typedef enum logic [1:0] {
    BURST_LINEAR = 2'b01,
    BURST_INTERLEAVED = 2'b10
  } ssdp_burst_t;
endpackage : ssdp_pkg
`default_nettype wire

// >>> ssdp_burst_ctr.sv
// burst address counter for the low address bits
`timescale 1ns/10ps
`default_nettype none
module ssdp_burst_ctr (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic advance,
  input wire logic [ssdp_pkg::BURST_BITS-1:0] base,
  input wire ssdp_pkg::ssdp_burst_t order,
  output logic [ssdp_pkg::BURST_BITS-1:0] lowAddr
);
  import ssdp_pkg::*;

  logic [BURST_BITS-1:0] base_q, base_d;
  logic [BURST_BITS-1:0] cnt_q, cnt_d;

  always_comb begin
    base_d = base_q;
    cnt_d = cnt_q;
    if (load) begin
      base_d = base;
      cnt_d = RST_BURST;
    end else if (advance) begin
      cnt_d = cnt_q + BURST_STEP;
    end
    unique case (order)
      BURST_LINEAR: lowAddr = base_d + cnt_d;
      BURST_INTERLEAVED: lowAddr = base_d ^ cnt_d;
      default: lowAddr = base_d ^ cnt_d;
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      base_q <= RST_BURST;
      cnt_q <= RST_BURST;
    end else begin
      base_q <= base_d;
      cnt_q <= cnt_d;
    end
  end
endmodule // ssdp_burst_ctr
`default_nettype wire

// >>> ssdp_data_port.sv
// data and parity port of a flow-through synchronous sram
`timescale 1ns/10ps
`default_nettype none
module ssdp_data_port #(
  parameter int BYTES = ssdp_pkg::DATA_BYTES,
  parameter int AW = ssdp_pkg::ADDR_BITS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ssdp_pkg::ssdp_cmd_t cmd,
  input wire logic outputEnableN,
  input wire logic burstModeStrap,
  input wire logic [BYTES*8-1:0] dqIn,
  output logic [BYTES*8-1:0] dqOut,
  output logic dqOeN,
  input wire logic [BYTES-1:0] bidirParityLinesIn,
  output logic [BYTES-1:0] bidirParityLinesOut,
  output logic bidirParityLinesOeN
);
  import ssdp_pkg::*;

  localparam int BB = BYTE_BITS + 1;
  localparam int BW = BURST_BITS;

  // each stored byte carries its parity bit on top
  logic [BYTES-1:0][BB-1:0] mem [2**AW];

  logic selected_q, selected_d;
  logic isWrite_q, isWrite_d;
  logic drive_q, drive_d;
  logic wrPend_q, wrPend_d;
  logic [BYTES-1:0] wrBytes_q, wrBytes_d;
  logic [AW-1:0] wrAddr_q, wrAddr_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [AW-BW-1:0] hiAddr_q, hiAddr_d;
  logic [BYTES*8-1:0] dqOut_q, dqOut_d;
  logic [BYTES-1:0] parOut_q, parOut_d;
  logic interleave_q, interleave_d;
  logic opActive;
  logic burstAdvance;
  logic [BW-1:0] lowAddr;
  ssdp_burst_t burstOrder;
  logic [BYTES-1:0][BB-1:0] rdWord;
  logic [BYTES-1:0][BB-1:0] inWord;
  logic [BYTES-1:0][BB-1:0] outWord;

  // strap is static; sampling it every clock keeps reset constant-only
  assign interleave_d = burstModeStrap;
  assign burstOrder = interleave_q ? BURST_INTERLEAVED : BURST_LINEAR;

  assign burstAdvance = cmd.advance & ~cmd.select & selected_q;
  assign opActive = cmd.select | burstAdvance;

  ssdp_burst_ctr u_burst (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(cmd.select),
    .advance(burstAdvance),
    .base(cmd.addr[BW-1:0]),
    .order(burstOrder),
    .lowAddr(lowAddr)
  );

  always_comb begin
    hiAddr_d = cmd.select ? cmd.addr[AW-1:BW] : hiAddr_q;
    addr_d = {hiAddr_d, lowAddr};
    selected_d = opActive;
    isWrite_d = cmd.select ? cmd.writeEn : (burstAdvance & isWrite_q);
    // no drive when deselected, in a write data phase, or on the first cycle back
    drive_d = opActive & ~isWrite_d & selected_q;
    // late write: data arrives the cycle after the address
    wrPend_d = opActive & isWrite_d;
    wrBytes_d = cmd.byteWriteSelect;
    wrAddr_d = addr_d;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      selected_q <= RST_SELECTED;
      isWrite_q <= RST_WRITE;
      drive_q <= RST_DRIVE;
      wrPend_q <= RST_WRITE;
      wrBytes_q <= '0;
      wrAddr_q <= '0;
      addr_q <= '0;
      hiAddr_q <= '0;
      interleave_q <= RST_INTERLEAVE;
    end else begin
      selected_q <= selected_d;
      isWrite_q <= isWrite_d;
      drive_q <= drive_d;
      wrPend_q <= wrPend_d;
      wrBytes_q <= wrBytes_d;
      wrAddr_q <= wrAddr_d;
      addr_q <= addr_d;
      hiAddr_q <= hiAddr_d;
      interleave_q <= interleave_d;
    end
  end

  // data path: capture, byte merge, bypass for write-then-read of one word
  assign rdWord = mem[addr_d];

  for (genvar b = 0; b < BYTES; b++) begin : g_byte
    assign inWord[b] = {bidirParityLinesIn[b], dqIn[b*8 +: 8]};
    assign outWord[b] = (wrPend_q && wrBytes_q[b] && (wrAddr_q == addr_d)) ?
                        inWord[b] : rdWord[b];
    assign dqOut_d[b*8 +: 8] = outWord[b][BYTE_BITS-1:0];
    assign parOut_d[b] = outWord[b][BYTE_BITS];
  end

  // memory is left unreset; its content is undefined after power up
  always_ff @(posedge mclk) begin
    for (int b = 0; b < BYTES; b++) begin
      if (wrPend_q && wrBytes_q[b]) begin
        mem[wrAddr_q][b] <= inWord[b];
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dqOut_q <= '0;
      parOut_q <= '0;
    end else begin
      dqOut_q <= dqOut_d;
      parOut_q <= parOut_d;
    end
  end

  assign dqOut = dqOut_q;
  assign bidirParityLinesOut = parOut_q;
  // output enable acts without the clock, so it gates the registered drive directly
  assign dqOeN = ~(drive_q & ~outputEnableN);
  assign bidirParityLinesOeN = ~(drive_q & ~outputEnableN);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence readCycle;
    selected_d && !isWrite_d;
  endsequence

  sequence writeCycle;
    selected_d && isWrite_d;
  endsequence

  sequence emergeCycle;
    !selected_d ##1 selected_d;
  endsequence

  oe_high_hiz_a: assert property (
    outputEnableN |-> dqOeN && bidirParityLinesOeN)
    else $error("lines driven while output enable high");

  read_drives_a: assert property (
    readCycle ##1 (readCycle and !outputEnableN) |=> (outputEnableN || !dqOeN))
    else $error("back to back read not driven");

  write_phase_hiz_a: assert property (
    writeCycle |=> dqOeN && bidirParityLinesOeN)
    else $error("driven during write data phase");

  emerge_hiz_a: assert property (
    emergeCycle |=> dqOeN)
    else $error("driven on first cycle after deselect");

  deselect_hiz_a: assert property (
    !selected_d |=> dqOeN ##0 bidirParityLinesOeN)
    else $error("driven while deselected");

  parity_follows_a: assert property (
    dqOeN == bidirParityLinesOeN)
    else $error("parity enable differs from data enable");

  write_capture_a: assert property (
    (wrPend_q && (&wrBytes_q)) |=> mem[$past(wrAddr_q)] == $past(inWord))
    else $error("write data not captured at clock edge");

  // per byte: stored word, masked bytes and the bypass of a write still in flight
  for (genvar b = 0; b < BYTES; b++) begin : g_byte_chk
    read_data_a: assert property (
      (readCycle and !wrPend_q) |=>
        dqOut_q[b*8 +: 8] == mem[addr_q][b][BYTE_BITS-1:0] &&
        parOut_q[b] == mem[addr_q][b][BYTE_BITS])
      else $error("read data not from registered address");

    byte_write_a: assert property (
      (wrPend_q && wrBytes_q[b]) |=> mem[$past(wrAddr_q)][b] == $past(inWord[b]))
      else $error("selected byte or parity not written");

    byte_keep_a: assert property (
      (wrPend_q && !wrBytes_q[b]) |=>
        mem[$past(wrAddr_q)][b] == $past(mem[wrAddr_q][b]))
      else $error("unselected byte or parity was written");

    bypass_read_a: assert property (
      (readCycle and (wrPend_q && wrBytes_q[b] && wrAddr_q == addr_d)) |=>
        {parOut_q[b], dqOut_q[b*8 +: 8]} == $past(inWord[b]))
      else $error("read after write missed the new byte");
  end

  burst_linear_a: assert property (
    (burstAdvance && !interleave_q) |-> addr_d[BW-1:0] == addr_q[BW-1:0] + BURST_STEP)
    else $error("linear burst step wrong");

  burst_interleave_a: assert property (
    (burstAdvance && interleave_q) |->
      ((addr_d[BW-1:0] ^ addr_q[BW-1:0]) inside {2'h1, 2'h3}) &&
      addr_d[AW-1:BW] == addr_q[AW-1:BW])
    else $error("interleaved burst step wrong");

  // a read right behind a write must drive with no dead cycle between them
  turnaround_a: assert property (
    writeCycle ##1 (readCycle and !outputEnableN) |=> (outputEnableN || !dqOeN))
    else $error("read after write not driven");

  // the first edge after reset still holds the reset order, so it is skipped
  strap_order_a: assert property (
    !$past(sys_rst) |-> interleave_q == $past(burstModeStrap))
    else $error("burst order not taken from strap");
endmodule // ssdp_data_port
`default_nettype wire

// >>> ssdp_ctrl_model.sv
// memory controller model that drives the sram bus
`timescale 1ns/10ps
`default_nettype none
module ssdp_ctrl_model (
  input wire logic mclk,
  output var ssdp_pkg::ssdp_cmd_t cmd,
  output logic [35:0] busDrv
);
  import ssdp_pkg::*;
  logic [35:0] wrData;
  initial begin
    cmd = '0;
    busDrv = '0;
    wrData = '0;
  end
  // write data only in the cycle after its address edge; inverted otherwise so stale data never matches
  always @(posedge mclk) begin
    if (cmd.writeEn && (cmd.select || cmd.advance)) busDrv <= wrData;
    else busDrv <= ~busDrv;
  end
  task automatic beat(input logic s, w, a, input logic [3:0] b, input logic [5:0] ad,
                      input logic [35:0] wd);
    @(posedge mclk);
    cmd <= '{s, w, a, b, 20'(ad)};
    wrData <= wd;
  endtask
endmodule // ssdp_ctrl_model
`default_nettype wire

// >>> ssdp_data_port_tb.sv
// self-checking bench for the sram data port
`timescale 1ns/10ps
`default_nettype none
module ssdp_data_port_tb;
  import ssdp_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic outputEnableN = 1'b0;
  logic burstModeStrap = 1'b1;
  ssdp_cmd_t cmd;
  logic [35:0] busDrv;
  logic [31:0] dqIn;
  logic [31:0] dqOut;
  logic [3:0] parIn;
  logic [3:0] parOut;
  logic dqOeN;
  logic parOeN;
  int numErrors = 0;
  int testsRun = 0;
  // the shared wire shows whichever side drives it
  assign dqIn = dqOeN ? busDrv[31:0] : dqOut;
  assign parIn = parOeN ? busDrv[35:32] : parOut;
  initial begin
    forever #2 mclk = ~mclk;
  end
  ssdp_ctrl_model ctl_u (.mclk(mclk), .cmd(cmd), .busDrv(busDrv));
  ssdp_data_port #(.AW(6)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd),
    .outputEnableN(outputEnableN), .burstModeStrap(burstModeStrap), .dqIn(dqIn),
    .dqOut(dqOut), .dqOeN(dqOeN), .bidirParityLinesIn(parIn),
    .bidirParityLinesOut(parOut), .bidirParityLinesOeN(parOeN));
  function automatic logic [35:0] pat(input int a);
    return {4'(a), 8'(a), 8'(~a), 8'h3c, 8'(a + 1)};
  endfunction
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // samples one step after the edge so that edge's updates have landed
  task automatic look(input logic oeN, input logic [35:0] exp);
    #1;
    check({34'h0, parOeN, dqOeN}, {34'h0, oeN, oeN});
    if (!oeN) check({parOut, dqOut}, exp);
  endtask
  task automatic t_reset();
    look(1'b1, '0);
    check({parOut, dqOut}, 36'h0);
  endtask
  task automatic t_write_read();
    logic [35:0] exp;
    for (int a = 0; a < 8; a++) begin
      ctl_u.beat(1, 1, 0, 4'hf, 6'(a), pat(a));
      if (a > 0) look(1'b1, '0);
    end
    ctl_u.beat(1, 1, 0, 4'h5, 6'h2, 36'hf_ffff_ffff);
    ctl_u.beat(1, 0, 0, 4'h0, 6'h2, '0);
    ctl_u.beat(0, 0, 0, 4'h0, 6'h0, '0);
    exp = pat(2);
    exp[7:0] = 8'hff;
    exp[23:16] = 8'hff;
    exp[32] = 1'b1;
    exp[34] = 1'b1;
    look(1'b0, exp);
  endtask
  // the second read would drive, so only output enable keeps the lines released
  task automatic t_oe();
    ctl_u.beat(1, 0, 0, 4'h0, 6'h1, '0);
    outputEnableN <= 1'b1;
    ctl_u.beat(1, 0, 0, 4'h0, 6'h1, '0);
    ctl_u.beat(0, 0, 0, 4'h0, 6'h0, '0);
    look(1'b1, '0);
    ctl_u.beat(1, 0, 0, 4'h0, 6'h1, '0);
    outputEnableN <= 1'b0;
    look(1'b1, '0);
    ctl_u.beat(1, 0, 0, 4'h0, 6'h1, '0);
    look(1'b1, '0);
    ctl_u.beat(0, 0, 0, 4'h0, 6'h0, '0);
    look(1'b0, pat(1));
  endtask
  // strap low steps the low bits upward with wrap, high steps them by xor
  task automatic t_burst(input logic strap, input int st);
    int ea;
    ctl_u.beat(1, 0, 0, 4'h0, 6'(st), '0);
    burstModeStrap <= strap;
    ctl_u.beat(1, 0, 0, 4'h0, 6'(st), '0);
    for (int i = 0; i < 4; i++) begin
      ea = strap ? (st ^ i) : ((st & 4) | ((st + i) & 3));
      ctl_u.beat(0, 0, i < 3, 4'h0, 6'h0, '0);
      look(1'b0, pat(ea));
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge mclk);
    numErrors++;
    results();
  end
  initial begin
    repeat (11) @(posedge mclk);
    t_reset();
    @(posedge mclk);
    sys_rst <= 1'b0;
    t_write_read();
    t_oe();
    t_burst(1'b0, 5);
    t_burst(1'b1, 5);
    results();
  end
endmodule // ssdp_data_port_tb
`default_nettype wire
